// ---- verilog/sfcr_dev.sv ----
/*
 * Flash command front end: opcode capture, decode, single-line normal
 * and fast read with wrapping address, pause support.
 * Assumes link pins are synchronous to CLK_I and the memory answers
 * MEM_DATA_I combinationally for MEM_ADDR_O.
 */
`timescale 1ns/1ps
module sfcr_dev
	import sfcr_pkg::*;
(
	// Clock and reset
	input  wire logic              CLK_I,
	input  wire logic              RST_I,
	// Serial link
	sfcr_if.dev                    LINK,
	// Memory array
	output logic      [ADDR_W-1:0] MEM_ADDR_O,
	input  wire logic [7:0]        MEM_DATA_I,
	// Program and erase engine
	input  wire logic              WRITE_IN_PROGRESS_I,
	// Decoded command report
	output sfcr_cmd_t              CMD_KIND_O,
	output logic                   CMD_STB_O,
	output logic                   READ_ACTIVE_O
);

	typedef struct packed {
		sfcr_dev_st_t      st;
		logic [2:0]        bitc;
		logic [1:0]        bytec;
		logic [7:0]        opc;
		logic [23:0]       addr;
		logic [7:0]        osh;
		logic              fast;
		logic              drv;
		logic              miso;
		logic              oe;
		logic              sck_q;
		logic [ADDR_W-1:0] mem_addr;
		sfcr_cmd_t         kind;
		logic              stb;
	} sfcr_dev_state_t;

	sfcr_dev_state_t r_reg;
	sfcr_dev_state_t r_next;

	function automatic sfcr_cmd_t decode(input logic [7:0] op);
		sfcr_cmd_t k;
		k = CMD_NONE;
		case (op)
			OP_READ:      k = CMD_READ;
			OP_FAST_READ: k = CMD_FAST_READ;
			OP_DUAL_IO:   k = CMD_DUAL_IO;
			OP_DUAL_OUT:  k = CMD_DUAL_OUT;
			OP_QUAD_IO:   k = CMD_QUAD_IO;
			OP_QUAD_OUT:  k = CMD_QUAD_OUT;
			OP_PAGE_PROG:                    k = CMD_PAGE_PROG;
			OP_QPROG_A, OP_QPROG_B:          k = CMD_QUAD_PROG;
			OP_SECT_ERASE_A, OP_SECT_ERASE_B: k = CMD_SECT_ERASE;
			OP_BLK32_ERASE:                  k = CMD_BLK32_ERASE;
			OP_BLK64_ERASE:                  k = CMD_BLK64_ERASE;
			OP_CHIP_ERASE_A, OP_CHIP_ERASE_B: k = CMD_CHIP_ERASE;
			OP_SUSPEND_A, OP_SUSPEND_B: k = CMD_SUSPEND;
			OP_RESUME_A, OP_RESUME_B:   k = CMD_RESUME;
			OP_DEEP_SLEEP:  k = CMD_DEEP_SLEEP;
			OP_IDENT_WAKE:  k = CMD_IDENT_WAKE;
			OP_STD_IDENT:   k = CMD_STD_IDENT;
			OP_MAKER_IDENT: k = CMD_MAKER_IDENT;
			default:        k = CMD_NONE;
		endcase
		return k;
	endfunction

	always_comb begin
		logic       rise;
		logic       fall;
		logic [7:0] op;
		rise = LINK.ser_clk & ~r_reg.sck_q;
		fall = ~LINK.ser_clk & r_reg.sck_q;
		op = {r_reg.opc[6:0], LINK.mosi};
		r_next = r_reg;
		r_next.stb = 1'b0;
		r_next.sck_q = LINK.ser_clk;
		if (LINK.sel_n) begin
			r_next.st = D_OPC;
			r_next.bitc = 3'h0;
			r_next.bytec = 2'h0;
			r_next.drv = 1'b0;
		end else if (!LINK.pause_n) begin
			r_next = r_reg;
			r_next.stb = 1'b0;
			r_next.sck_q = LINK.ser_clk;
		end else begin
			case (r_reg.st)
				D_OPC: begin
					if (rise) begin
						r_next.opc = op;
						r_next.bitc = r_reg.bitc + 3'h1;
						if (r_reg.bitc == BIT_LAST) begin
							r_next.kind = decode(op);
							r_next.stb = 1'b1;
							r_next.fast = (op == OP_FAST_READ);
							// reads go on to the address unless a write is in progress
							if ((op == OP_READ || op == OP_FAST_READ) &&
							    !WRITE_IN_PROGRESS_I) begin
								r_next.st = D_ADDR;
							end else begin
								r_next.st = D_IGN;
							end
						end
					end
				end
				D_ADDR: begin
					if (rise) begin
						r_next.addr = {r_reg.addr[22:0], LINK.mosi};
						r_next.bitc = r_reg.bitc + 3'h1;
						if (r_reg.bitc == BIT_LAST) begin
							r_next.bytec = r_reg.bytec + 2'h1;
							if (r_reg.bytec == ADDR_LAST) begin
								r_next.mem_addr = r_next.addr[ADDR_W-1:0];
								// fast read takes a dummy byte
								r_next.st = r_reg.fast ? D_DUMMY : D_DATA;
							end
						end
					end
				end
				D_DUMMY: begin
					if (rise) begin
						r_next.bitc = r_reg.bitc + 3'h1;
						if (r_reg.bitc == BIT_LAST) begin
							r_next.st = D_DATA;
						end
					end
				end
				D_DATA: begin
					// input line no longer looked at
					if (fall) begin
						r_next.drv = 1'b1;
						r_next.bitc = r_reg.bitc + 3'h1;
						if (r_reg.bitc == 3'h0) begin
							r_next.miso = MEM_DATA_I[7];
							r_next.osh = {MEM_DATA_I[6:0], 1'b0};
							// advance and wrap at the top
							r_next.mem_addr = r_reg.mem_addr + 1'b1;
						end else begin
							r_next.miso = r_reg.osh[7];
							r_next.osh = {r_reg.osh[6:0], 1'b0};
						end
					end
				end
				D_IGN: begin
					r_next.drv = 1'b0;
				end
				default: begin
					r_next.st = D_IGN;
				end
			endcase
		end
		// output floats while paused or idle
		r_next.oe = r_next.drv & ~LINK.sel_n & LINK.pause_n;
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign LINK.miso     = r_reg.miso;
	assign LINK.miso_oe  = r_reg.oe;
	assign MEM_ADDR_O    = r_reg.mem_addr;
	assign CMD_KIND_O    = r_reg.kind;
	assign CMD_STB_O     = r_reg.stb;
	assign READ_ACTIVE_O = r_reg.drv;

endmodule // sfcr_dev

// ---- verilog/sfcr_pkg.sv ----
/*
 * Shared constants and types for the serial flash command front end
 * and its host controller.
 * Assumes both ends run on one 100 MHz system clock.
 */
package sfcr_pkg;

	// Opcodes
	localparam logic [7:0] OP_READ         = 8'h03;
	localparam logic [7:0] OP_FAST_READ    = 8'h0b;
	localparam logic [7:0] OP_DUAL_IO      = 8'hbb;
	localparam logic [7:0] OP_DUAL_OUT     = 8'h3b;
	localparam logic [7:0] OP_QUAD_IO      = 8'heb;
	localparam logic [7:0] OP_QUAD_OUT     = 8'h6b;
	localparam logic [7:0] OP_PAGE_PROG    = 8'h02;
	localparam logic [7:0] OP_QPROG_A      = 8'h32;
	localparam logic [7:0] OP_QPROG_B      = 8'h38;
	localparam logic [7:0] OP_SECT_ERASE_A = 8'hd7;
	localparam logic [7:0] OP_SECT_ERASE_B = 8'h20;
	localparam logic [7:0] OP_BLK32_ERASE  = 8'h52;
	localparam logic [7:0] OP_BLK64_ERASE  = 8'hd8;
	localparam logic [7:0] OP_CHIP_ERASE_A = 8'hc7;
	localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
	localparam logic [7:0] OP_SUSPEND_A    = 8'h75;
	localparam logic [7:0] OP_SUSPEND_B    = 8'hb0;
	localparam logic [7:0] OP_RESUME_A     = 8'h7a;
	localparam logic [7:0] OP_RESUME_B     = 8'h30;
	localparam logic [7:0] OP_DEEP_SLEEP   = 8'hb9;
	localparam logic [7:0] OP_IDENT_WAKE   = 8'hab;
	localparam logic [7:0] OP_STD_IDENT    = 8'h9f;
	localparam logic [7:0] OP_MAKER_IDENT  = 8'h90;

	// Address framing
	localparam int         ADDR_BYTES = 3;
	localparam int         ADDR_W     = 22;
	localparam logic [1:0] ADDR_LAST  = 2'(ADDR_BYTES - 1);
	localparam logic [2:0] BIT_LAST   = 3'h7;
	localparam logic [7:0] DUMMY_BYTE = 8'h00;

	// Transmit bit counts on the host side
	localparam logic [5:0] TX_CMD_ONLY = 6'h08;
	localparam logic [5:0] TX_READ     = 6'h20;
	localparam logic [5:0] TX_FAST     = 6'h28;

	// Serial clock timing
	localparam int CLK_MHZ      = 100;
	localparam int SCK_NORM_MHZ = 33;
	localparam int SCK_FAST_MHZ = 104;
	localparam int NORM_HALF_RAW =
		(CLK_MHZ + 2 * SCK_NORM_MHZ - 1) / (2 * SCK_NORM_MHZ);
	localparam int FAST_HALF_RAW =
		(CLK_MHZ + 2 * SCK_FAST_MHZ - 1) / (2 * SCK_FAST_MHZ);
	// Two cycles per half period at least so the far end sees each level
	localparam logic [3:0] SCK_NORM_HALF =
		4'((NORM_HALF_RAW < 2) ? 2 : NORM_HALF_RAW);
	localparam logic [3:0] SCK_FAST_HALF =
		4'((FAST_HALF_RAW < 2) ? 2 : FAST_HALF_RAW);

	typedef enum logic [4:0] {
		CMD_NONE, CMD_READ, CMD_FAST_READ, CMD_DUAL_IO, CMD_DUAL_OUT,
		CMD_QUAD_IO, CMD_QUAD_OUT, CMD_PAGE_PROG, CMD_QUAD_PROG,
		CMD_SECT_ERASE, CMD_BLK32_ERASE, CMD_BLK64_ERASE, CMD_CHIP_ERASE,
		CMD_SUSPEND, CMD_RESUME, CMD_DEEP_SLEEP, CMD_IDENT_WAKE,
		CMD_STD_IDENT, CMD_MAKER_IDENT
	} sfcr_cmd_t;

	typedef enum logic [2:0] {
		D_OPC, D_ADDR, D_DUMMY, D_DATA, D_IGN
	} sfcr_dev_st_t;

	typedef enum logic [2:0] {
		H_IDLE, H_LOW, H_HIGH, H_END
	} sfcr_host_st_t;

endpackage

// ---- verilog/sfcr_if.sv ----
/*
 * Serial link between flash command front end and host controller.
 * Assumes the testbench instantiates it and joins both ends to it.
 */
`timescale 1ns/1ps
interface sfcr_if;
	logic ser_clk;
	logic sel_n;
	logic pause_n;
	logic mosi;
	logic miso;
	logic miso_oe;
	logic miso_line;

	// Released data-out line reads as the inverse of its last value
	assign miso_line = miso_oe ? miso : ~miso;

	modport dev (
		input  ser_clk, sel_n, pause_n, mosi,
		output miso, miso_oe
	);
	modport host (
		output ser_clk, sel_n, pause_n, mosi,
		input  miso_line
	);
endinterface

// ---- verilog/sfcr_host.sv ----
/*
 * Host controller for the flash command front end: sends opcode,
 * address for reads and dummy byte for fast read, collects read bytes, honours pause requests.
 * Assumes a single system clock; the serial clock is divided from it.
 */
`timescale 1ns/1ps
module sfcr_host
	import sfcr_pkg::*;
(
	// Clock and reset
	input  wire logic        CLK_I,
	input  wire logic        RST_I,
	// Serial link
	sfcr_if.host             LINK,
	// Command request
	input  wire logic        START_I,
	input  wire logic [7:0]  OPCODE_I,
	input  wire logic [23:0] ADDR_I,
	input  wire logic [15:0] LEN_I,
	input  wire logic        HOLD_REQ_I,
	// Results
	output logic             BUSY_O,
	output logic [7:0]       RDATA_O,
	output logic             RVALID_O,
	output logic             DONE_O
);

	typedef struct packed {
		sfcr_host_st_t st;
		logic [3:0]    cnt;
		logic [3:0]    half;
		logic          sck;
		logic          sel_n;
		logic          pause_n;
		logic          mosi;
		logic [39:0]   txsh;
		logic [5:0]    tx_left;
		logic [19:0]   total;
		logic [7:0]    rx;
		logic [2:0]    rxbits;
		logic [7:0]    rdata;
		logic          rvalid;
		logic          done;
		logic          busy;
	} sfcr_host_state_t;

	sfcr_host_state_t r_reg;
	sfcr_host_state_t r_next;

	always_comb begin
		logic       is_read;
		logic       is_fast;
		logic [5:0] tx_n;
		is_read = (OPCODE_I == OP_READ) || (OPCODE_I == OP_FAST_READ);
		is_fast = (OPCODE_I == OP_FAST_READ);
		tx_n = is_fast ? TX_FAST : (is_read ? TX_READ : TX_CMD_ONLY);
		r_next = r_reg;
		r_next.rvalid = 1'b0;
		r_next.done = 1'b0;
		case (r_reg.st)
			H_IDLE: begin
				r_next.sel_n = 1'b1;
				r_next.pause_n = 1'b1;
				r_next.sck = 1'b0;
				if (START_I) begin
					// fast read carries a dummy byte
					r_next.txsh = {OPCODE_I, ADDR_I, DUMMY_BYTE};
					r_next.mosi = OPCODE_I[7];
					r_next.tx_left = tx_n;
					r_next.total = is_read ?
						20'({LEN_I, 3'b000}) + 20'(tx_n) : 20'(tx_n);
					// normal read takes SCK_NORM_HALF; it and SCK_FAST_HALF both come to 2 cycles
					r_next.half = (OPCODE_I == OP_READ) ?
						SCK_NORM_HALF : SCK_FAST_HALF;
					r_next.cnt = 4'h0;
					r_next.rxbits = 3'h0;
					r_next.sel_n = 1'b0;
					r_next.busy = 1'b1;
					r_next.st = H_LOW;
				end
			end
			H_LOW: begin
				if (HOLD_REQ_I && r_reg.pause_n) begin
					r_next.pause_n = 1'b0;
				end else if (!HOLD_REQ_I && !r_reg.pause_n) begin
					r_next.pause_n = 1'b1;
				end else if (r_reg.pause_n) begin
					r_next.cnt = r_reg.cnt + 4'h1;
					if (r_reg.cnt == r_reg.half - 4'h1) begin
						r_next.sck = 1'b1;
						r_next.cnt = 4'h0;
						r_next.st = H_HIGH;
					end
				end
			end
			H_HIGH: begin
				r_next.cnt = r_reg.cnt + 4'h1;
				if (r_reg.cnt == r_reg.half - 4'h1) begin
					r_next.cnt = 4'h0;
					r_next.sck = 1'b0;
					r_next.total = r_reg.total - 20'h1;
					if (r_reg.tx_left == 6'h0) begin
						r_next.rx = {r_reg.rx[6:0], LINK.miso_line};
						r_next.rxbits = r_reg.rxbits + 3'h1;
						if (r_reg.rxbits == BIT_LAST) begin
							r_next.rdata = {r_reg.rx[6:0], LINK.miso_line};
							r_next.rvalid = 1'b1;
						end
					end else begin
						r_next.tx_left = r_reg.tx_left - 6'h1;
						r_next.txsh = {r_reg.txsh[38:0], 1'b0};
						r_next.mosi = r_reg.txsh[38];
					end
					r_next.st = (r_reg.total == 20'h1) ? H_END : H_LOW;
				end
			end
			H_END: begin
				r_next.cnt = r_reg.cnt + 4'h1;
				if (r_reg.cnt == r_reg.half - 4'h1) begin
					r_next.sel_n = 1'b1;
					r_next.busy = 1'b0;
					r_next.done = 1'b1;
					r_next.st = H_IDLE;
				end
			end
			default: begin
				r_next.st = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			r_reg <= '0;
			r_reg.sel_n <= 1'b1;
			r_reg.pause_n <= 1'b1;
		end else begin
			r_reg <= r_next;
		end
	end

	assign LINK.ser_clk = r_reg.sck;
	assign LINK.sel_n   = r_reg.sel_n;
	assign LINK.pause_n = r_reg.pause_n;
	assign LINK.mosi    = r_reg.mosi;
	assign BUSY_O       = r_reg.busy;
	assign RDATA_O      = r_reg.rdata;
	assign RVALID_O     = r_reg.rvalid;
	assign DONE_O       = r_reg.done;

endmodule // sfcr_host

// ---- sim/sfcr_monitor.sv ----
/* Link checker for the flash front end and its host controller.
   Assumes the bench wires it beside the shared link interface. */
`timescale 1ns/1ps
module sfcr_monitor (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// Serial link
	input wire logic ser_clk_i,
	input wire logic sel_n_i,
	input wire logic pause_n_i,
	input wire logic mosi_i,
	input wire logic miso_i,
	input wire logic miso_oe_i
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (RST_I);

	a_desel_out_off: assert property (
		sel_n_i ##1 sel_n_i |-> !miso_oe_i)
		else $error("data out driven while deselected");
	a_pause_out_off: assert property (
		!pause_n_i ##1 !pause_n_i |-> !miso_oe_i)
		else $error("data out driven while paused");
	a_pause_in_low: assert property (
		$fell(pause_n_i) |-> !ser_clk_i)
		else $error("pause entered with clock high");
	a_pause_out_low: assert property (
		$rose(pause_n_i) |-> !ser_clk_i && !$past(ser_clk_i))
		else $error("pause left with clock high");
	a_pause_clk_frozen: assert property (
		!pause_n_i |-> !ser_clk_i)
		else $error("clock ran during pause");
	a_idle_clk_low: assert property (
		sel_n_i |-> !ser_clk_i)
		else $error("clock high while deselected");
	a_sel_setup: assert property (
		$fell(sel_n_i) |-> !ser_clk_i ##1 !ser_clk_i)
		else $error("select fell without clock setup");
	a_mosi_steady: assert property (
		ser_clk_i && !sel_n_i |-> $stable(mosi_i))
		else $error("data in moved while clock high");
	a_miso_steady: assert property (
		ser_clk_i && miso_oe_i |-> $stable(miso_i))
		else $error("data out moved while clock high");
	a_out_start_low: assert property (
		$rose(miso_oe_i) && $past(pause_n_i, 2) |-> !ser_clk_i)
		else $error("data out started on clock high");
	a_clk_high_min: assert property (
		$rose(ser_clk_i) |=> ser_clk_i)
		else $error("clock high phase too short");
	a_clk_low_min: assert property (
		$fell(ser_clk_i) |=> !ser_clk_i)
		else $error("clock low phase too short");
endmodule // sfcr_monitor

// ---- sim/serial_flash_cmd_read_hold_tb.sv ----
/* Self-checking bench joining host controller and flash front end.
   Assumes the package and link interface are compiled first. */
`timescale 1ns/1ps
module serial_flash_cmd_read_hold_tb
	import sfcr_pkg::*;
;
	logic        clk, rst, start, hold, write_in_progress, busy, rvalid, done;
	logic        stb, ract, seen_oe, seen_pause, seen_ract, seen_busy;
	logic [7:0]  opcode, rdata, mem_data;
	logic [23:0] addr;
	logic [15:0] len;
	logic [21:0] mem_addr;
	sfcr_cmd_t   kind, seen_kind;
	logic [7:0]  got[$];
	int          err_total, comparisons, stbs;

	// Memory contents derived from the address
	function automatic logic [7:0] mem_val(logic [21:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3c;
	endfunction
	assign mem_data = mem_val(mem_addr);

	sfcr_if link();
	sfcr_dev i_sfcr_dev (.CLK_I(clk), .RST_I(rst), .LINK(link.dev),
		.MEM_ADDR_O(mem_addr), .MEM_DATA_I(mem_data),
		.WRITE_IN_PROGRESS_I(write_in_progress), .CMD_KIND_O(kind), .CMD_STB_O(stb),
		.READ_ACTIVE_O(ract));
	sfcr_host i_sfcr_host (.CLK_I(clk), .RST_I(rst), .LINK(link.host),
		.START_I(start), .OPCODE_I(opcode), .ADDR_I(addr), .LEN_I(len),
		.HOLD_REQ_I(hold), .BUSY_O(busy), .RDATA_O(rdata),
		.RVALID_O(rvalid), .DONE_O(done));
	sfcr_monitor i_sfcr_monitor (.CLK_I(clk), .RST_I(rst),
		.ser_clk_i(link.ser_clk), .sel_n_i(link.sel_n),
		.pause_n_i(link.pause_n), .mosi_i(link.mosi),
		.miso_i(link.miso), .miso_oe_i(link.miso_oe));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(string what, logic [23:0] exp, logic [23:0] act);
		comparisons++;
		if (act !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, act);
		end
	endtask

	task automatic end_sim;
		if (err_total == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// One host command, recording what the link and device report
	task automatic run(logic [7:0] op, logic [23:0] a, int n, int hold_at);
		int i;
		got.delete();
		stbs = 0;
		seen_oe = 1'b0;
		seen_pause = 1'b0;
		seen_ract = 1'b0;
		seen_busy = 1'b0;
		seen_kind = CMD_NONE;
		@(negedge clk);
		opcode = op;
		addr = a;
		len = 16'(n);
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		for (i = 0; i < 3000; i++) begin
			@(negedge clk);
			if (rvalid === 1'b1) got.push_back(rdata);
			if (stb === 1'b1) begin
				stbs++;
				seen_kind = kind;
			end
			if (link.miso_oe === 1'b1) seen_oe = 1'b1;
			if (link.pause_n === 1'b0) seen_pause = 1'b1;
			if (ract === 1'b1) seen_ract = 1'b1;
			if (busy === 1'b1) seen_busy = 1'b1;
			// Two pause windows: address phase, then data phase
			hold = (i >= hold_at && i < hold_at + 20) ||
				(i >= hold_at + 100 && i < hold_at + 120);
			if (done === 1'b1) break;
		end
		if (i == 3000) begin
			err_total++;
			end_sim();
		end
	endtask

	task automatic t_read;
		run(8'h03, 24'hc01234, 2, 99999);
		chk("read kind", CMD_READ, seen_kind);
		chk("read count", 2, got.size());
		chk("read byte0", mem_val(22'h001234), got[0]);
		chk("read byte1", mem_val(22'h001235), got[1]);
		chk("read active", 1, seen_ract);
		chk("read busy", 1, seen_busy);
		chk("read busy end", 0, busy);
		chk("read deselect", 1, link.sel_n);
		@(negedge clk);
		chk("read active end", 0, ract);
		chk("read drive end", 0, link.miso_oe);
	endtask

	task automatic t_fast_wrap;
		run(8'h0b, 24'hffffff, 2, 99999);
		chk("fast kind", CMD_FAST_READ, seen_kind);
		chk("fast count", 2, got.size());
		chk("fast byte0", mem_val(22'h3fffff), got[0]);
		chk("fast byte1", mem_val(22'h000000), got[1]);
	endtask

	task automatic t_pause;
		run(8'h03, 24'h000200, 2, 60);
		chk("pause seen", 1, seen_pause);
		chk("pause count", 2, got.size());
		chk("pause byte0", mem_val(22'h000200), got[0]);
		chk("pause byte1", mem_val(22'h000201), got[1]);
	endtask

	task automatic t_busy;
		write_in_progress = 1'b1;
		run(8'h03, 24'h000010, 1, 99999);
		write_in_progress = 1'b0;
		chk("busy kind", CMD_READ, seen_kind);
		chk("busy drive", 0, seen_oe);
		chk("busy active", 0, seen_ract);
	endtask

	task automatic t_decode;
		logic [7:0] ops[22] = '{8'hbb, 8'h3b, 8'heb, 8'h6b, 8'h02, 8'h32,
			8'h38, 8'hd7, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60, 8'h75, 8'hb0,
			8'h7a, 8'h30, 8'hb9, 8'hab, 8'h9f, 8'h90, 8'h48};
		sfcr_cmd_t kinds[22] = '{CMD_DUAL_IO, CMD_DUAL_OUT, CMD_QUAD_IO,
			CMD_QUAD_OUT, CMD_PAGE_PROG, CMD_QUAD_PROG, CMD_QUAD_PROG,
			CMD_SECT_ERASE, CMD_SECT_ERASE, CMD_BLK32_ERASE,
			CMD_BLK64_ERASE, CMD_CHIP_ERASE, CMD_CHIP_ERASE, CMD_SUSPEND,
			CMD_SUSPEND, CMD_RESUME, CMD_RESUME, CMD_DEEP_SLEEP,
			CMD_IDENT_WAKE, CMD_STD_IDENT, CMD_MAKER_IDENT, CMD_NONE};
		for (int k = 0; k < 22; k++) begin
			run(ops[k], 24'h000000, 1, 99999);
			chk("decode kind", kinds[k], seen_kind);
			chk("decode strobes", 1, stbs);
			chk("decode drive", 0, seen_oe);
		end
	endtask

	initial begin
		rst = 1'b1;
		start = 1'b0;
		hold = 1'b0;
		write_in_progress = 1'b0;
		opcode = 8'h00;
		addr = 24'h000000;
		len = 16'h0000;
		err_total = 0;
		comparisons = 0;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		t_read();
		t_fast_wrap();
		t_pause();
		t_busy();
		t_decode();
		end_sim();
	end
endmodule // serial_flash_cmd_read_hold_tb
